// [logic/tpc_pkg.sv]
// Package of constants and types for the throttle position calibration block
package tpc_pkg;

	// Width of signed millivolt quantities
	localparam int VW = 16;
	// Clock rate and derived cycles per millisecond
	localparam int CLK_HZ = 100_000_000;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	// Default settle time between drive steps, in ms
	localparam int STEP_TIME_MS = 20;
	// Full analog input scale in millivolts (0 to 5 V)
	localparam logic signed [15:0] ADC_MIN_MV = 16'sh0000;
	localparam logic signed [15:0] ADC_MAX_MV = 16'sh1388;
	// Reset value of learned and output ranges
	localparam logic signed [15:0] RANGE_RST = 16'sh0000;

	typedef enum logic [6:0] {
		TPC_IDLE = 7'b000_0001,
		TPC_INIT = 7'b000_0010,
		TPC_POS = 7'b000_0100,
		TPC_PAUSE = 7'b000_1000,
		TPC_NEG = 7'b001_0000,
		TPC_RET = 7'b010_0000,
		TPC_POST = 7'b100_0000
	} tpc_state_t;

endpackage : tpc_pkg

// [logic/tpc_cal.sv]
// Position calibration sequencer for one throttle channel
`timescale 1ns/1ps

//***************************************************************
// Operation
//***************************************************************
// Operation
// - Wait the initial delay in seconds before the positive sweep starts.
// - Negative sweep end goes to post; the return state with its second delay is never entered.
// - Positive sweep starts with the programmed initial positive drive.
// - Negative sweep starts with the programmed initial negative drive.
// - On each positive stall raise drive by the positive step.
// - On each negative stall lower drive by the negative step.
// - Positive step sum that would exceed its limit stops drive, goes negative.
// - Negative step sum that would pass below its limit stops drive, goes post.
// - Track primary sensor; change below offset counts as no movement.
// - Span below threshold at finish raises the span fault.
// - A span fault leaves the success flag cleared.
// - Each sensor holds a range in seeded order: element 0 at minimum, 1 at maximum, swapped where the seeded min exceeds max.
// - Sensor inputs span 0 to 5 volts.
// - A two-element position range is held, minimum then maximum.
// - Until calibrated, outputs equal the calibration inputs.
// - After a run, sensor range outputs take the learned values.
// - Primary-select input decides which sensor feeds primary output.
module tpc_cal #(
	parameter int STEP_CYCLES = tpc_pkg::STEP_TIME_MS * tpc_pkg::MS_CYCLES,
	parameter int SEC_CYCLES = tpc_pkg::CLK_HZ
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cal_start,
	input wire logic [7:0] cal_init_delay,
	input wire logic [7:0] neg_to_pos_delay,
	input wire logic signed [15:0] pos_sweep_initial_drive,
	input wire logic signed [15:0] neg_sweep_initial_drive,
	input wire logic signed [15:0] pos_drive_step,
	input wire logic signed [15:0] neg_drive_step,
	input wire logic signed [15:0] pos_step_limit,
	input wire logic signed [15:0] neg_step_limit,
	input wire logic signed [15:0] movement_offset,
	input wire logic signed [15:0] span_threshold,
	input wire logic primary_sensor_select,
	input wire logic signed [15:0] sensor1_mv,
	input wire logic signed [15:0] sensor2_mv,
	input wire logic signed [15:0] sensor1_range_min,
	input wire logic signed [15:0] sensor1_range_max,
	input wire logic signed [15:0] sensor2_range_min,
	input wire logic signed [15:0] sensor2_range_max,
	input wire logic signed [15:0] plate_position_range_min,
	input wire logic signed [15:0] plate_position_range_max,
	output logic signed [15:0] motor_drive,
	output logic cal_busy,
	output logic span_fault,
	output logic cal_success_flag,
	output logic signed [15:0] primary_range_out_min,
	output logic signed [15:0] primary_range_out_max,
	output logic signed [15:0] secondary_range_out_min,
	output logic signed [15:0] secondary_range_out_max,
	output logic signed [15:0] plate_position_range_out_min,
	output logic signed [15:0] plate_position_range_out_max
);

	//***************************************************************
	// Helpers
	//***************************************************************
	function automatic logic signed [15:0] clamp_mv(
		input logic signed [15:0] v
	);
		if (v < tpc_pkg::ADC_MIN_MV)
			return tpc_pkg::ADC_MIN_MV;
		else if (v > tpc_pkg::ADC_MAX_MV)
			return tpc_pkg::ADC_MAX_MV;
		else
			return v;
	endfunction : clamp_mv

	function automatic logic signed [15:0] absdiff(
		input logic signed [15:0] a,
		input logic signed [15:0] b
	);
		logic signed [16:0] d;
		d = 17'(a) - 17'(b);
		if (d < 0)
			d = -d;
		return (d > 17'sh0_7FFF) ? 16'sh7FFF : d[15:0];
	endfunction : absdiff

	//***************************************************************
	// Input synchronisers
	//***************************************************************
	logic [1:0] start_sync_r;
	logic start_d_r;
	logic signed [15:0] s1_a_r, s1_b_r, s2_a_r, s2_b_r;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			start_sync_r <= 2'b00;
			start_d_r <= 1'b0;
			s1_a_r <= 16'sh0000;
			s1_b_r <= 16'sh0000;
			s2_a_r <= 16'sh0000;
			s2_b_r <= 16'sh0000;
		end else begin
			start_sync_r <= {start_sync_r[0], cal_start};
			start_d_r <= start_sync_r[1];
			s1_a_r <= sensor1_mv;
			s1_b_r <= s1_a_r;
			s2_a_r <= sensor2_mv;
			s2_b_r <= s2_a_r;
		end
	end

	logic start_evt;
	logic signed [15:0] s1_v, s2_v, prim_v;
	assign start_evt = start_sync_r[1] & ~start_d_r;
	assign s1_v = clamp_mv(s1_b_r);
	assign s2_v = clamp_mv(s2_b_r);
	assign prim_v = primary_sensor_select ? s1_v : s2_v;

	//***************************************************************
	// Sequencer
	//***************************************************************
	tpc_pkg::tpc_state_t st_r, st_nxt;
	logic [31:0] tmr_r, tmr_nxt;
	logic [7:0] sec_r, sec_nxt;
	logic signed [15:0] drv_r, drv_nxt, acc_r, acc_nxt, ref_r, ref_nxt;
	logic signed [15:0] s1lo_r, s1lo_nxt, s1hi_r, s1hi_nxt;
	logic signed [15:0] s2lo_r, s2lo_nxt, s2hi_r, s2hi_nxt;
	logic done_r, done_nxt, fault_r, fault_nxt, ok_r, ok_nxt;
	logic tick;
	logic moved_up, moved_dn;

	assign tick = (tmr_r == 32'(STEP_CYCLES - 1));
	assign moved_up = (prim_v - ref_r) >= movement_offset;
	assign moved_dn = (ref_r - prim_v) >= movement_offset;

	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r + 32'd1;
		sec_nxt = sec_r;
		drv_nxt = drv_r;
		acc_nxt = acc_r;
		ref_nxt = ref_r;
		s1lo_nxt = s1lo_r;
		s1hi_nxt = s1hi_r;
		s2lo_nxt = s2lo_r;
		s2hi_nxt = s2hi_r;
		done_nxt = done_r;
		fault_nxt = fault_r;
		ok_nxt = ok_r;
		case (st_r)
			tpc_pkg::TPC_IDLE: begin
				tmr_nxt = 32'd0;
				drv_nxt = 16'sh0000;
				if (start_evt) begin
					st_nxt = tpc_pkg::TPC_INIT;
					sec_nxt = 8'd0;
					ok_nxt = 1'b0;
					fault_nxt = 1'b0;
				end
			end
			tpc_pkg::TPC_INIT, tpc_pkg::TPC_RET: begin
				if (tmr_r == 32'(SEC_CYCLES - 1)) begin
					tmr_nxt = 32'd0;
					sec_nxt = sec_r + 8'd1;
				end
				if (sec_r >= ((st_r == tpc_pkg::TPC_INIT) ?
						cal_init_delay : neg_to_pos_delay)) begin
					st_nxt = tpc_pkg::TPC_POS;
					tmr_nxt = 32'd0;
					drv_nxt = pos_sweep_initial_drive;
					acc_nxt = 16'sh0000;
					ref_nxt = prim_v;
					s1lo_nxt = s1_v;
					s1hi_nxt = s1_v;
					s2lo_nxt = s2_v;
					s2hi_nxt = s2_v;
				end
			end
			tpc_pkg::TPC_POS, tpc_pkg::TPC_NEG: begin
				// Extremes per sensor, element 0 at min, 1 at max
				if (s1_v < s1lo_r) s1lo_nxt = s1_v;
				if (s1_v > s1hi_r) s1hi_nxt = s1_v;
				if (s2_v < s2lo_r) s2lo_nxt = s2_v;
				if (s2_v > s2hi_r) s2hi_nxt = s2_v;
				if (tick) begin
					tmr_nxt = 32'd0;
					ref_nxt = prim_v;
					if (st_r == tpc_pkg::TPC_POS) begin
						if (!moved_up) begin
							if (acc_r + pos_drive_step > pos_step_limit) begin
								st_nxt = tpc_pkg::TPC_PAUSE;
								drv_nxt = 16'sh0000;
							end else begin
								acc_nxt = acc_r + pos_drive_step;
								drv_nxt = drv_r + pos_drive_step;
							end
						end
					end else if (!moved_dn) begin
						if (acc_r + neg_drive_step < neg_step_limit) begin
							st_nxt = tpc_pkg::TPC_POST;
							drv_nxt = 16'sh0000;
						end else begin
							acc_nxt = acc_r + neg_drive_step;
							drv_nxt = drv_r + neg_drive_step;
						end
					end
				end
			end
			tpc_pkg::TPC_PAUSE: begin
				if (tick) begin
					st_nxt = tpc_pkg::TPC_NEG;
					tmr_nxt = 32'd0;
					drv_nxt = neg_sweep_initial_drive;
					acc_nxt = 16'sh0000;
					ref_nxt = prim_v;
				end
			end
			tpc_pkg::TPC_POST: begin
				st_nxt = tpc_pkg::TPC_IDLE;
				done_nxt = 1'b1;
				// Span of the sensor chosen as primary, not of a value match
				if (absdiff(primary_sensor_select ? s1hi_r : s2hi_r,
						primary_sensor_select ? s1lo_r : s2lo_r) <
						span_threshold) begin
					fault_nxt = 1'b1;
					ok_nxt = 1'b0;
				end else begin
					ok_nxt = 1'b1;
				end
			end
			default: begin
				st_nxt = tpc_pkg::TPC_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= tpc_pkg::TPC_IDLE;
			tmr_r <= 32'd0;
			sec_r <= 8'd0;
			drv_r <= 16'sh0000;
			acc_r <= 16'sh0000;
			ref_r <= 16'sh0000;
			s1lo_r <= tpc_pkg::RANGE_RST;
			s1hi_r <= tpc_pkg::RANGE_RST;
			s2lo_r <= tpc_pkg::RANGE_RST;
			s2hi_r <= tpc_pkg::RANGE_RST;
			done_r <= 1'b0;
			fault_r <= 1'b0;
			ok_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			sec_r <= sec_nxt;
			drv_r <= drv_nxt;
			acc_r <= acc_nxt;
			ref_r <= ref_nxt;
			s1lo_r <= s1lo_nxt;
			s1hi_r <= s1hi_nxt;
			s2lo_r <= s2lo_nxt;
			s2hi_r <= s2hi_nxt;
			done_r <= done_nxt;
			fault_r <= fault_nxt;
			ok_r <= ok_nxt;
		end
	end

	//***************************************************************
	// Calibration outputs
	//***************************************************************
	logic signed [15:0] p0_nxt, p1_nxt, q0_nxt, q1_nxt, a0, a1, b0, b1;

	always_comb begin
		// Learned values keep the polarity that software seeded
		a0 = sensor1_range_min;
		a1 = sensor1_range_max;
		b0 = sensor2_range_min;
		b1 = sensor2_range_max;
		if (done_r) begin
			a0 = (sensor1_range_min <= sensor1_range_max) ? s1lo_r : s1hi_r;
			a1 = (sensor1_range_min <= sensor1_range_max) ? s1hi_r : s1lo_r;
			b0 = (sensor2_range_min <= sensor2_range_max) ? s2lo_r : s2hi_r;
			b1 = (sensor2_range_min <= sensor2_range_max) ? s2hi_r : s2lo_r;
		end
		p0_nxt = primary_sensor_select ? a0 : b0;
		p1_nxt = primary_sensor_select ? a1 : b1;
		q0_nxt = primary_sensor_select ? b0 : a0;
		q1_nxt = primary_sensor_select ? b1 : a1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			motor_drive <= 16'sh0000;
			cal_busy <= 1'b0;
			span_fault <= 1'b0;
			cal_success_flag <= 1'b0;
			primary_range_out_min <= tpc_pkg::RANGE_RST;
			primary_range_out_max <= tpc_pkg::RANGE_RST;
			secondary_range_out_min <= tpc_pkg::RANGE_RST;
			secondary_range_out_max <= tpc_pkg::RANGE_RST;
			plate_position_range_out_min <= tpc_pkg::RANGE_RST;
			plate_position_range_out_max <= tpc_pkg::RANGE_RST;
		end else begin
			motor_drive <= drv_r;
			cal_busy <= (st_r != tpc_pkg::TPC_IDLE);
			span_fault <= fault_r;
			cal_success_flag <= ok_r;
			primary_range_out_min <= p0_nxt;
			primary_range_out_max <= p1_nxt;
			secondary_range_out_min <= q0_nxt;
			secondary_range_out_max <= q1_nxt;
			plate_position_range_out_min <= plate_position_range_min;
			plate_position_range_out_max <= plate_position_range_max;
		end
	end

endmodule : tpc_cal

// [sim/tpc_cal_assertions.sv]
// Checker on the motor drive and result flags of the calibration sequencer
`timescale 1ns/1ps
module tpc_cal_assertions (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cal_busy,
	input wire logic span_fault,
	input wire logic cal_success_flag,
	input wire logic signed [15:0] motor_drive,
	input wire logic signed [15:0] pos_sweep_initial_drive,
	input wire logic signed [15:0] neg_sweep_initial_drive,
	input wire logic signed [15:0] pos_drive_step,
	input wire logic signed [15:0] neg_drive_step,
	input wire logic signed [15:0] pos_step_limit,
	input wire logic signed [15:0] neg_step_limit
);
	localparam logic signed [15:0] ZERO = 16'sh0000;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic signed [15:0] prv_r, prv_nxt;
	always_comb prv_nxt = motor_drive;
	always_ff @(posedge sys_clk) prv_r <= prv_nxt;
	sequence s_pos_end;
		prv_r > ZERO && motor_drive == ZERO;
	endsequence
	sequence s_neg_end;
		prv_r < ZERO && motor_drive == ZERO;
	endsequence
	property p_pinit;
		prv_r == ZERO && motor_drive > ZERO
			|-> motor_drive == pos_sweep_initial_drive;
	endproperty
	a_pinit: assert property (p_pinit) else $error("pos start");
	property p_ninit;
		prv_r == ZERO && motor_drive < ZERO
			|-> motor_drive == neg_sweep_initial_drive;
	endproperty
	a_ninit: assert property (p_ninit) else $error("neg start");
	property p_pinc;
		prv_r > ZERO && motor_drive > prv_r
			|-> motor_drive - prv_r == pos_drive_step;
	endproperty
	a_pinc: assert property (p_pinc) else $error("pos step");
	property p_ndec;
		prv_r < ZERO && motor_drive < prv_r
			|-> motor_drive - prv_r == neg_drive_step;
	endproperty
	a_ndec: assert property (p_ndec) else $error("neg step");
	property p_pend;
		s_pos_end |-> prv_r - pos_sweep_initial_drive
			+ pos_drive_step > pos_step_limit;
	endproperty
	a_pend: assert property (p_pend) else $error("pos stop");
	property p_nend;
		s_neg_end |-> prv_r - neg_sweep_initial_drive
			+ neg_drive_step < neg_step_limit;
	endproperty
	a_nend: assert property (p_nend) else $error("neg stop");
	property p_excl;
		span_fault |-> !cal_success_flag;
	endproperty
	a_excl: assert property (p_excl) else $error("fault and success");
	property p_idle;
		$fell(cal_busy) |-> motor_drive == ZERO;
	endproperty
	a_idle: assert property (p_idle) else $error("drive at end");
endmodule : tpc_cal_assertions
bind tpc_cal tpc_cal_assertions u_chk (.sys_clk, .rst_n, .cal_busy,
	.span_fault, .cal_success_flag, .motor_drive, .pos_sweep_initial_drive,
	.neg_sweep_initial_drive, .pos_drive_step, .neg_drive_step,
	.pos_step_limit, .neg_step_limit);

// [sim/tpc_plate_model.sv]
// Throttle body model: motor moves the plate between two end stops
`timescale 1ns/1ps
module tpc_plate_model (
	input wire logic sys_clk,
	input wire logic signed [15:0] motor_drive,
	output logic signed [15:0] sensor1_mv,
	output logic signed [15:0] sensor2_mv
);
	// Moves only beyond a breakaway drive; stops at 500 and 4500 mV
	logic signed [15:0] pos_r = 16'sh09c4;
	always @(posedge sys_clk) begin
		if (motor_drive > 16'sh07d0 && pos_r < 16'sh1194)
			pos_r <= pos_r + 16'sh000a;
		if (motor_drive < 16'shf830 && pos_r > 16'sh01f4)
			pos_r <= pos_r - 16'sh000a;
	end
	assign sensor1_mv = pos_r;
	assign sensor2_mv = 16'sh1388 - pos_r;
endmodule : tpc_plate_model

// [sim/tpc_cal_test.sv]
// Self-checking bench of the calibration sequencer
`timescale 1ns/1ps
module tpc_cal_test;
	typedef struct {
		logic signed [15:0] thr;
		logic fault;
		logic ok;
	} tpc_row_t;
	// Plate travel 500 to 4500 mV gives a span of 4000 mV
	tpc_row_t rows[3] = '{'{16'sh0bb8, 1'b0, 1'b1},
		'{16'sh0fa1, 1'b1, 1'b0}, '{16'sh0fa0, 1'b0, 1'b1}};
	logic sys_clk, rst_n, cal_start, primary_sensor_select;
	logic cal_busy, span_fault, cal_success_flag;
	logic [7:0] cal_init_delay, neg_to_pos_delay;
	logic signed [15:0] pos_sweep_initial_drive, neg_sweep_initial_drive;
	logic signed [15:0] pos_drive_step, neg_drive_step, pos_step_limit;
	logic signed [15:0] neg_step_limit, movement_offset, span_threshold;
	logic signed [15:0] sensor1_mv, sensor2_mv, motor_drive;
	logic signed [15:0] sensor1_range_min, sensor1_range_max;
	logic signed [15:0] sensor2_range_min, sensor2_range_max;
	logic signed [15:0] plate_position_range_min, plate_position_range_max;
	logic signed [15:0] primary_range_out_min, primary_range_out_max;
	logic signed [15:0] secondary_range_out_min, secondary_range_out_max;
	logic signed [15:0] plate_position_range_out_min;
	logic signed [15:0] plate_position_range_out_max;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	tpc_cal #(.STEP_CYCLES(8), .SEC_CYCLES(16)) DUT (.*);
	tpc_plate_model plate (.*);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task check(input string nm, input logic signed [15:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
		end
	endtask : check
	task stop_test;
		$display("Checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 8000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		rst_n = 1'b0;
		cal_start = 1'b0;
		primary_sensor_select = 1'b1;
		cal_init_delay = 8'h01;
		neg_to_pos_delay = 8'h01;
		{pos_sweep_initial_drive, neg_sweep_initial_drive, pos_drive_step,
			neg_drive_step, pos_step_limit, neg_step_limit, movement_offset,
			span_threshold} = {16'sh0bb8, 16'shf448, 16'sh00c8, 16'shff38,
			16'sh044c, 16'shfbb4, 16'sh0005, 16'sh0bb8};
		// Sensor 1 rising, sensor 2 falling; ranges set only while idle
		{sensor1_range_min, sensor1_range_max, sensor2_range_min,
			sensor2_range_max} = {16'sh0000, 16'sh1388,
			16'sh1388, 16'sh0000};
		plate_position_range_min = 16'sh0000;
		plate_position_range_max = 16'sh0064;
		tick(8);
		rst_n = 1'b1;
		tick(3);
		check("primary_min", 16'sh0000, primary_range_out_min);
		check("plate_max", 16'sh0064, plate_position_range_out_max);
		primary_sensor_select = 1'b0;
		tick(3);
		check("primary_min", 16'sh1388, primary_range_out_min);
		check("secondary_max", 16'sh1388, secondary_range_out_max);
		primary_sensor_select = 1'b1;
		$display("Test of outputs before calibration done");
		foreach (rows[i]) begin
			span_threshold = rows[i].thr;
			tick(2);
			cal_start = 1'b1;
			while (cal_busy !== 1'b1) tick(1);
			cal_start = 1'b0;
			tick(12);
			check("drive", 16'sh0000, motor_drive);
			tick(8);
			check("drive", 16'sh0bb8, motor_drive);
			while (cal_busy !== 1'b0) tick(1);
			tick(2);
			check("span_fault", rows[i].fault, span_fault);
			check("success", rows[i].ok, cal_success_flag);
			check("primary_min", 16'sh01f4, primary_range_out_min);
			check("primary_max", 16'sh1194, primary_range_out_max);
			check("secondary_min", 16'sh1194, secondary_range_out_min);
			$display("Test of calibration row %0d done", i);
		end
		primary_sensor_select = 1'b0;
		tick(3);
		check("primary_min", 16'sh1194, primary_range_out_min);
		check("secondary_max", 16'sh1194, secondary_range_out_max);
		$display("Test of select after calibration done");
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(3);
		check("busy", 16'sh0000, cal_busy);
		check("primary_min", 16'sh1388, primary_range_out_min);
		check("secondary_min", 16'sh0000, secondary_range_out_min);
		$display("Test of reset after calibration done");
		stop_test();
	end
endmodule : tpc_cal_test
